// ==== rtl/grb_pkg.sv ====
// Constants shared by the general register bank and its fuse array.
package grb_pkg;
	localparam logic [7:0]  GRB_WRITE_FLAG      = 8'h80;
	localparam logic [6:0]  GRB_ADDR_GLOBAL_STATUS_FLAGS      = 7'h01;
	localparam logic [6:0]  GRB_ADDR_WRITE_TRANSFER_COUNTER      = 7'h02;
	localparam logic [6:0]  GRB_ADDR_NODE_REPLY_CONFIG   = 7'h03;
	localparam logic [6:0]  GRB_ADDR_FUSE_PROG  = 7'h04;
	localparam logic [6:0]  GRB_ADDR_FUSE_READ  = 7'h05;
	localparam logic [6:0]  GRB_ADDR_PIN_STATE  = 7'h06;
	localparam int          GRB_WRITE_FLAG_BIT  = 7;
	localparam int          GRB_GLOBAL_STATUS_FLAGS_RESET_BIT = 0;
	localparam int          GRB_GLOBAL_STATUS_FLAGS_DRVERR_BIT = 1;
	localparam int          GRB_GLOBAL_STATUS_FLAGS_UV_BIT    = 2;
	localparam int          GRB_DELAY_LSB       = 8;
	localparam int          GRB_DELAY_MSB       = 11;
	localparam int          GRB_FUSE_BIT_LSB    = 0;
	localparam int          GRB_FUSE_BIT_MSB    = 2;
	localparam int          GRB_FUSE_BYTE_LSB   = 4;
	localparam int          GRB_FUSE_BYTE_MSB   = 5;
	localparam int          GRB_FUSE_KEY_LSB    = 8;
	localparam int          GRB_FUSE_KEY_MSB    = 15;
	localparam logic [7:0]  GRB_FUSE_UNLOCK_KEY = 8'hbd;
	localparam logic [1:0]  GRB_FUSE_BYTES      = 2'h3;
	localparam logic [2:0]  GRB_GLOBAL_STATUS_FLAGS_RESET_VAL = 3'h1;
	localparam logic [3:0]  GRB_DELAY_RESET_VAL = 4'h0;
	localparam logic [7:0]  GRB_COUNT_RESET_VAL = 8'h00;
	localparam logic [23:0] GRB_FUSE_RESET_VAL  = 24'h000000;
	localparam logic [31:0] GRB_ZERO_WORD       = 32'h00000000;
	localparam logic [7:0]  GRB_BIT_TIMES_UNIT  = 8'h08;
endpackage

// ==== rtl/grb_fuse_array.sv ====
// One-time fuse array: set-only storage of three fuse bytes.
`timescale 1ns/1ns
module grb_fuse_array
	import grb_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	input  wire logic        prog_strobe_in,
	input  wire logic [15:0] prog_word_in,
	output logic      [23:0] fuse_bits_out
);
	logic [23:0] fuse_bits_reg;
	logic [7:0]  key;
	logic [1:0]  byte_sel;
	logic [2:0]  bit_sel;

	assign key      = prog_word_in[GRB_FUSE_KEY_MSB:GRB_FUSE_KEY_LSB];
	assign byte_sel = prog_word_in[GRB_FUSE_BYTE_MSB:GRB_FUSE_BYTE_LSB];
	assign bit_sel  = prog_word_in[GRB_FUSE_BIT_MSB:GRB_FUSE_BIT_LSB];

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			fuse_bits_reg <= GRB_FUSE_RESET_VAL;
		end else begin
			if (prog_strobe_in && key == GRB_FUSE_UNLOCK_KEY && byte_sel < GRB_FUSE_BYTES) begin
				fuse_bits_reg[{byte_sel, bit_sel}] <= 1'b1;
			end
		end
	end

	assign fuse_bits_out = fuse_bits_reg;
endmodule

// ==== rtl/grb_register_bank.sv ====
// General configuration register bank reached by decoded serial datagrams.
`timescale 1ns/1ns
// Operation
// - Address plus 0x80 writes; plain address reads that register.
// - Every register loads zero at power-up unless another default applies.
// - Writing one to a status bit clears that latched flag.
// - Status bit 0 sets on reset and holds until cleared.
// - Status bit 1 latches on shutdown; clear works only without errors.
// - Status bit 2 shows live pump undervoltage and disables power stage.
// - Counter increments per good write datagram, reads leave it alone.
// - Counter wraps from its maximum to zero.
// - Reply delay is (value or 1) times eight bit times.
// - Programming write sets one selected fuse bit in byte 0, 1 or 2.
// - Fuses program only with the unlock key in the upper byte.
// - Reading the programming location refreshes fuse readback data.
// - Readback holds fuse bytes 0, 1, 2 in ascending byte lanes.
// - Pin state register returns three live input levels and one zero bit in bits 0 to 3.
module grb_register_bank
	import grb_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	input  wire logic        dgram_valid_in,
	input  wire logic [7:0]  dgram_addr_in,
	input  wire logic [31:0] dgram_data_in,
	input  wire logic        drv_error_active_in,
	input  wire logic        pump_undervoltage_in,
	input  wire logic        variant_select_in,
	input  wire logic        driver_disable_input_in,
	input  wire logic        powerdown_serial_pin_in,
	input  wire logic        microstep_select_a_in,
	input  wire logic        microstep_select_b_in,
	input  wire logic        chopper_select_pin_in,
	input  wire logic        direction_pin_in,
	output logic             reply_valid_out,
	output logic      [31:0] reply_data_out,
	output logic      [7:0]  reply_delay_bits_out,
	output logic             power_stage_enable_out
);
	logic [2:0]  global_status_flags_reg;
	logic [7:0]  write_transfer_counter_reg;
	logic [3:0]  reply_delay_setting_reg;
	logic [23:0] fuse_readback_reg;
	logic        fuse_load_pending_reg;
	logic        reply_valid_reg;
	logic [31:0] reply_data_reg;
	logic [7:0]  reply_delay_bits_reg;
	logic        power_stage_enable_reg;
	logic        is_write;
	logic        is_read;
	logic [6:0]  reg_addr;
	logic [23:0] fuse_bits;
	logic [3:0]  pin_state;
	logic [31:0] read_word;

	function automatic logic [7:0] delay_bit_times(input logic [3:0] setting);
		delay_bit_times = 8'({4'h0, setting | 4'h1} * GRB_BIT_TIMES_UNIT);
	endfunction

	// write flag splits writes from reads.
	assign is_write = dgram_valid_in && dgram_addr_in[GRB_WRITE_FLAG_BIT];
	assign is_read  = dgram_valid_in && !dgram_addr_in[GRB_WRITE_FLAG_BIT];
	assign reg_addr = dgram_addr_in[6:0];

	grb_fuse_array u_fuse (
		.core_clk_in    (core_clk_in),
		.reset_in       (reset_in),
		.prog_strobe_in (is_write && reg_addr == GRB_ADDR_FUSE_PROG),
		.prog_word_in   (dgram_data_in[15:0]),
		.fuse_bits_out  (fuse_bits)
	);

	// reset flag starts set, others clear.
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			global_status_flags_reg <= GRB_GLOBAL_STATUS_FLAGS_RESET_VAL;
		end else begin
			// write-one clear of the reset flag.
			if (is_write && reg_addr == GRB_ADDR_GLOBAL_STATUS_FLAGS && dgram_data_in[GRB_GLOBAL_STATUS_FLAGS_RESET_BIT]) begin
				global_status_flags_reg[GRB_GLOBAL_STATUS_FLAGS_RESET_BIT] <= 1'b0;
			end
			// latch on error; clear only once errors are gone.
			if (drv_error_active_in) begin
				global_status_flags_reg[GRB_GLOBAL_STATUS_FLAGS_DRVERR_BIT] <= 1'b1;
			end else if (is_write && reg_addr == GRB_ADDR_GLOBAL_STATUS_FLAGS && dgram_data_in[GRB_GLOBAL_STATUS_FLAGS_DRVERR_BIT]) begin
				global_status_flags_reg[GRB_GLOBAL_STATUS_FLAGS_DRVERR_BIT] <= 1'b0;
			end
			global_status_flags_reg[GRB_GLOBAL_STATUS_FLAGS_UV_BIT] <= pump_undervoltage_in;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			write_transfer_counter_reg <= GRB_COUNT_RESET_VAL;
		end else if (is_write) begin
			write_transfer_counter_reg <= write_transfer_counter_reg + 8'h01;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reply_delay_setting_reg <= GRB_DELAY_RESET_VAL;
		end else if (is_write && reg_addr == GRB_ADDR_NODE_REPLY_CONFIG) begin
			reply_delay_setting_reg <= dgram_data_in[GRB_DELAY_MSB:GRB_DELAY_LSB];
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			fuse_readback_reg     <= GRB_FUSE_RESET_VAL;
			fuse_load_pending_reg <= 1'b1;
		end else begin
			fuse_load_pending_reg <= 1'b0;
			// read of programming location refreshes readback.
			if (fuse_load_pending_reg || (is_read && reg_addr == GRB_ADDR_FUSE_PROG)) begin
				fuse_readback_reg <= fuse_bits;
			end
		end
	end

	// pin assignment follows the package variant.
	always_comb begin
		if (variant_select_in) begin
			pin_state = {microstep_select_b_in, microstep_select_a_in, 1'b0, driver_disable_input_in};
		end else begin
			pin_state = {direction_pin_in, chopper_select_pin_in, powerdown_serial_pin_in, 1'b0};
		end
	end

	// write-only and unmapped locations read as zero.
	always_comb begin
		read_word = GRB_ZERO_WORD;
		unique case (reg_addr)
			GRB_ADDR_GLOBAL_STATUS_FLAGS: begin
				read_word[2:0] = {pump_undervoltage_in, global_status_flags_reg[GRB_GLOBAL_STATUS_FLAGS_DRVERR_BIT:GRB_GLOBAL_STATUS_FLAGS_RESET_BIT]};
			end
			GRB_ADDR_WRITE_TRANSFER_COUNTER: begin
				read_word[7:0] = write_transfer_counter_reg;
			end
			GRB_ADDR_FUSE_READ: begin
				// byte 0 low, byte 2 high.
				read_word[23:0] = fuse_readback_reg;
			end
			GRB_ADDR_PIN_STATE: begin
				read_word[3:0] = pin_state;
			end
			default: begin
				read_word = GRB_ZERO_WORD;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reply_valid_reg <= 1'b0;
			reply_data_reg  <= GRB_ZERO_WORD;
		end else begin
			reply_valid_reg <= is_read;
			if (is_read) begin
				reply_data_reg <= read_word;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reply_delay_bits_reg   <= GRB_BIT_TIMES_UNIT;
			power_stage_enable_reg <= 1'b0;
		end else begin
			reply_delay_bits_reg <= delay_bit_times(reply_delay_setting_reg);
			// undervoltage or active error disables power stage.
			power_stage_enable_reg <= !pump_undervoltage_in && !drv_error_active_in;
		end
	end

	assign reply_valid_out        = reply_valid_reg;
	assign reply_data_out         = reply_data_reg;
	assign reply_delay_bits_out   = reply_delay_bits_reg;
	assign power_stage_enable_out = power_stage_enable_reg;
endmodule

// ==== verification/grb_host_model.sv ====
// Host model that issues register datagrams to the bank.
`timescale 1ns/1ns
module grb_host_model(
	input  wire logic        core_clk_in,
	output logic             valid_out,
	output logic      [7:0]  addr_out,
	output logic      [31:0] data_out
);
	initial begin
		valid_out = 1'b0;
		addr_out = 8'h00;
		data_out = 32'h00000000;
	end
	task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
		@(negedge core_clk_in);
		valid_out = 1'b1;
		addr_out = {w, a};
		data_out = d;
		@(negedge core_clk_in);
		valid_out = 1'b0;
		addr_out = ~addr_out;
		data_out = ~data_out;
		if (w && a == 7'h04) repeat (3) @(negedge core_clk_in);
	endtask
endmodule

// ==== verification/grb_checker.sv ====
// Assertions on the register bank ports.
`timescale 1ns/1ns
module grb_checker(
	input wire logic        core_clk_in,
	input wire logic        reset_in,
	input wire logic        dgram_valid_in,
	input wire logic [7:0]  dgram_addr_in,
	input wire logic        drv_error_active_in,
	input wire logic        pump_undervoltage_in,
	input wire logic        variant_select_in,
	input wire logic        driver_disable_input_in,
	input wire logic        microstep_select_a_in,
	input wire logic        microstep_select_b_in,
	input wire logic        reply_valid_out,
	input wire logic [31:0] reply_data_out,
	input wire logic [7:0]  reply_delay_bits_out,
	input wire logic        power_stage_enable_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	wire logic       rd = dgram_valid_in && !dgram_addr_in[7];
	wire logic [6:0] ra = dgram_addr_in[6:0];
	AST_RD_ANS: assert property (rd |=> reply_valid_out)
		else $error("read not answered");
	AST_WR_QUIET: assert property (dgram_valid_in && dgram_addr_in[7] |=> !reply_valid_out)
		else $error("write answered");
	AST_CNT_STILL: assert property (rd && ra == 7'h02 ##1 !dgram_valid_in ##1 rd && ra == 7'h02 |=> $stable(reply_data_out))
		else $error("counter moved on read");
	AST_DLY_FMT: assert property (reply_delay_bits_out[3:0] == 4'h8)
		else $error("delay not odd multiple of eight");
	AST_UV_OFF: assert property (pump_undervoltage_in |=> !power_stage_enable_out)
		else $error("power stage on in undervoltage");
	AST_UV_LIVE: assert property (rd && ra == 7'h01 |=> reply_data_out[2] == $past(pump_undervoltage_in))
		else $error("undervoltage bit not live");
	AST_ERR_SET: assert property (rd && ra == 7'h01 && $past(drv_error_active_in) |=> reply_data_out[1])
		else $error("error flag not set");
	AST_WO_ZERO: assert property (rd && (ra == 7'h03 || ra == 7'h04) |=> reply_data_out == 32'h00000000)
		else $error("write only read not zero");
	AST_PIN_A: assert property (rd && ra == 7'h06 && variant_select_in |=> reply_data_out == {28'h0000000,
		$past(microstep_select_b_in), $past(microstep_select_a_in), 1'b0, $past(driver_disable_input_in)})
		else $error("pin state wrong");
	cover property (rd && ra == 7'h05);
	cover property (dgram_valid_in && dgram_addr_in == 8'h84);
	cover property (rd && pump_undervoltage_in);
endmodule
bind grb_register_bank grb_checker chk(.*);

// ==== verification/driver_general_register_bank_tb_top.sv ====
// Self-checking bench for the general register bank.
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module driver_general_register_bank_tb_top;
	import grb_pkg::*;
	logic        core_clk_in, reset_in, err, uv, vs, dis, pdn, msa, msb, chop, dir, valid, rv, pse;
	logic [7:0]  addr, dly;
	logic [31:0] data, rdat;
	int          bad_count, cmp_count, cnt, fz, i, v;
	grb_host_model h(.core_clk_in(core_clk_in), .valid_out(valid), .addr_out(addr), .data_out(data));
	grb_register_bank dut(.core_clk_in(core_clk_in), .reset_in(reset_in), .dgram_valid_in(valid),
		.dgram_addr_in(addr), .dgram_data_in(data), .drv_error_active_in(err), .pump_undervoltage_in(uv),
		.variant_select_in(vs), .driver_disable_input_in(dis), .powerdown_serial_pin_in(pdn),
		.microstep_select_a_in(msa), .microstep_select_b_in(msb), .chopper_select_pin_in(chop),
		.direction_pin_in(dir), .reply_valid_out(rv), .reply_data_out(rdat), .reply_delay_bits_out(dly),
		.power_stage_enable_out(pse));
	task automatic final_report();
		$display("checks %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] e);
		h.xfer(1'b0, a, 32'h00000000);
		`CHK("reply", {1'b1, e}, {rv, rdat})
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		h.xfer(1'b1, a, d);
		cnt++;
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	initial begin
		#200000;
		bad_count++;
		final_report();
	end
	initial begin
		{reset_in, err, uv, vs, dis, pdn, msa, msb, chop, dir} = 10'h200;
		v = $urandom(48302);
		repeat (3) @(negedge core_clk_in);
		reset_in = 1'b0;
		rd_chk(7'h01, 32'h1);
		rd_chk(7'h02, 32'h0);
		rd_chk(7'h05, 32'h0);
		wr(7'h01, 32'h6);
		rd_chk(7'h01, 32'h1);
		wr(7'h01, 32'h1);
		rd_chk(7'h01, 32'h0);
		err = 1'b1;
		wr(7'h01, 32'h2);
		rd_chk(7'h01, 32'h2);
		`CHK("enable", 1'b0, pse)
		err = 1'b0;
		rd_chk(7'h01, 32'h2);
		wr(7'h01, 32'h2);
		uv = 1'b1;
		rd_chk(7'h01, 32'h4);
		`CHK("enable", 1'b0, pse)
		uv = 1'b0;
		rd_chk(7'h01, 32'h0);
		`CHK("enable", 1'b1, pse)
		for (v = 0; v < 16; v++) begin
			wr(7'h03, v << 8);
			repeat (2) @(negedge core_clk_in);
			`CHK("delay", 8'((v | 1) * 8), dly)
		end
		rd_chk(7'h03, 32'h0);
		for (i = 0; i < 8; i++) begin
			v = $urandom;
			wr(7'h04, {16'h0, (i == 7) ? 8'h5a : GRB_FUSE_UNLOCK_KEY, 2'h0, v[5:4], 1'h0, v[2:0]});
			if (i != 7 && v[5:4] != 2'h3) fz = fz | (1 << (v[5:4] * 8 + v[2:0]));
		end
		rd_chk(7'h04, 32'h0);
		rd_chk(7'h05, fz);
		for (i = 0; i < 256; i++) wr(7'h02, $urandom);
		rd_chk(7'h02, cnt & 255);
		rd_chk(7'h02, cnt & 255);
		for (i = 0; i < 8; i++) begin
			{vs, dis, pdn, msa, msb, chop, dir} = 7'($urandom);
			rd_chk(7'h06, vs ? {28'h0, msb, msa, 1'b0, dis} : {28'h0, dir, chop, pdn, 1'b0});
		end
		final_report();
	end
endmodule
